// file: core/dcr_pkg.sv
// Constants for the decoder control register bank, registers 7 and 9 to C.
// Assumes a 4-bit address and 4-bit data write port driven by the host.
// Behaviour
// - Reg7 low field picks status pin source.
// - Reg7 bit2 inverts DAC sample values.
// - Reg7 bit3 swaps channel order, inverts word select.
// - Reg9 selects PLL equalization, reset 0011.
// - RegA bit1 picks audio output source.
// - RegA bits2,0 encode clock accuracy level.
// - RegA both set: output off low; bit3 flags.
// - RegB selects standby/operating state and speed.
// - RegC bit0 selects external off-track input.
// - RegC bit1 kill type; bit2 drives pin three.
// - RegC bit3 selects soft or hard mute.
// - Reset loads every field's initial value.
// - Writes land only when shadow select is 00.
package dcr_pkg;
    // ************************************************************
    // Register offsets.
    // ************************************************************
    localparam logic [3:0] DCR_OFS_DAC_STATUS = 4'h7;
    localparam logic [3:0] DCR_OFS_PLL_EQ = 4'h9;
    localparam logic [3:0] DCR_OFS_AUDIO_OUT = 4'hA;
    localparam logic [3:0] DCR_OFS_SPEED = 4'hB;
    localparam logic [3:0] DCR_OFS_PIN_KILL = 4'hC;
    // ************************************************************
    // Reset values.
    // ************************************************************
    localparam logic [3:0] DCR_RST_DAC_STATUS = 4'h0;
    localparam logic [3:0] DCR_RST_PLL_EQ = 4'h3;
    localparam logic [3:0] DCR_RST_AUDIO_OUT = 4'h2;
    localparam logic [3:0] DCR_RST_SPEED = 4'h0;
    localparam logic [3:0] DCR_RST_PIN_KILL = 4'h2;
    // ************************************************************
    // Field positions and codes.
    // ************************************************************
    localparam int DCR_BIT_DAC_INV = 2;
    localparam int DCR_BIT_CH_SWAP = 3;
    localparam int DCR_BIT_AFTER_CONCEAL = 1;
    localparam int DCR_BIT_ACC_LO = 0;
    localparam int DCR_BIT_ACC_HI = 2;
    localparam int DCR_BIT_FLAGS_IN = 3;
    localparam int DCR_BIT_EXT_OFFTRACK = 0;
    localparam int DCR_BIT_MONO_KILL = 1;
    localparam int DCR_BIT_PIN_THREE = 2;
    localparam int DCR_BIT_HARD_MUTE = 3;
    localparam logic [1:0] DCR_STAT_SERVO = 2'h0;
    localparam logic [1:0] DCR_STAT_DECODER = 2'h2;
    localparam logic [1:0] DCR_SHADOW_MAIN = 2'h0;
    localparam logic [2:0] DCR_ST_STOP = 3'h0;
    localparam logic [2:0] DCR_ST_PAUSE = 3'h2;
    localparam logic [2:0] DCR_ST_OPER = 3'h3;
    localparam logic [1:0] DCR_SPD_DOUBLE = 2'h2;
endpackage

// file: core/dcr_nibble_reg.sv
// One 4-bit write-only control register with its own address.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module dcr_nibble_reg #(
    parameter logic [3:0] ADDR = 4'h0,
    parameter logic [3:0] RESET_VAL = 4'h0
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [3:0] addr_i,
    input wire logic [3:0] data_i,
    output logic [3:0] value_o
);
    logic [3:0] value_q;

    // The whole nibble is replaced at once, so no half-written code is ever seen.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            value_q <= RESET_VAL;
        end else if (wr_en_i && addr_i == ADDR) begin
            value_q <= data_i;
        end
    end

    assign value_o = value_q;
endmodule
`default_nettype wire

// file: core/dcr_regs.sv
// Decoder control register bank for registers 7 and 9 to C, with decoded controls.
// Assumes the host write strobe, address and data are synchronous to clock_i.
`timescale 1ns/10ps
`default_nettype none
module dcr_regs (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [3:0] wr_addr_i,
    input wire logic [3:0] wr_data_i,
    input wire logic [1:0] shadow_bank_select_i,
    input wire logic servo_irq_i,
    input wire logic decoder_status_i,
    input wire logic off_track_internal_i,
    input wire logic off_track_input_pin_i,
    input wire logic [15:0] dac_sample_i,
    input wire logic word_select_i,
    input wire logic audio_pre_conceal_i,
    input wire logic audio_post_conceal_i,
    output logic status_pin_o,
    output logic [15:0] dac_sample_o,
    output logic word_select_o,
    output logic right_first_o,
    output logic [3:0] pll_eq_code_o,
    output logic audio_out_o,
    output logic audio_out_enable_o,
    output logic [1:0] clock_accuracy_level_o,
    output logic insert_error_flags_o,
    output logic stop_standby_state_o,
    output logic pause_standby_state_o,
    output logic operating_state_o,
    output logic double_speed_o,
    output logic off_track_o,
    output logic off_track_pin_status_o,
    output logic mono_kill_o,
    output logic general_output_pin_three_o,
    output logic hard_mute_variant_o
);
    // ************************************************************
    // Register storage.
    // ************************************************************
    // Write strobe that only fires while the main bank is selected.
    logic main_wr;
    // Raw register nibbles, one per address.
    logic [3:0] dac_status_r;
    logic [3:0] pll_eq_r;
    logic [3:0] audio_r;
    logic [3:0] speed_r;
    logic [3:0] pin_kill_r;
    // Registered copies of the data paths, and the combinational audio off decode.
    logic [15:0] dac_sample_q;
    logic word_select_q;
    logic status_pin_q;
    logic audio_out_q;
    logic off_track_q;
    logic off_track_pin_q;
    logic audio_off;

    // While a shadow bank is selected, the main bank ignores every address.
    assign main_wr = wr_en_i && (shadow_bank_select_i == dcr_pkg::DCR_SHADOW_MAIN);

    // Status pin source, DAC polarity and channel order.
    dcr_nibble_reg #(
        .ADDR(dcr_pkg::DCR_OFS_DAC_STATUS),
        .RESET_VAL(dcr_pkg::DCR_RST_DAC_STATUS)
    ) u_reg7 (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .wr_en_i(main_wr),
        .addr_i(wr_addr_i),
        .data_i(wr_data_i),
        .value_o(dac_status_r)
    );

    // Bit clock regenerator equalization code.
    dcr_nibble_reg #(
        .ADDR(dcr_pkg::DCR_OFS_PLL_EQ),
        .RESET_VAL(dcr_pkg::DCR_RST_PLL_EQ)
    ) u_reg9 (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .wr_en_i(main_wr),
        .addr_i(wr_addr_i),
        .data_i(wr_data_i),
        .value_o(pll_eq_r)
    );

    // Digital audio output source, accuracy level and flag insertion.
    dcr_nibble_reg #(
        .ADDR(dcr_pkg::DCR_OFS_AUDIO_OUT),
        .RESET_VAL(dcr_pkg::DCR_RST_AUDIO_OUT)
    ) u_rega (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .wr_en_i(main_wr),
        .addr_i(wr_addr_i),
        .data_i(wr_data_i),
        .value_o(audio_r)
    );

    // Standby or operating state and disc speed.
    dcr_nibble_reg #(
        .ADDR(dcr_pkg::DCR_OFS_SPEED),
        .RESET_VAL(dcr_pkg::DCR_RST_SPEED)
    ) u_regb (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .wr_en_i(main_wr),
        .addr_i(wr_addr_i),
        .data_i(wr_data_i),
        .value_o(speed_r)
    );

    // Off-track source, kill type, pin three level and mute type.
    dcr_nibble_reg #(
        .ADDR(dcr_pkg::DCR_OFS_PIN_KILL),
        .RESET_VAL(dcr_pkg::DCR_RST_PIN_KILL)
    ) u_regc (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .wr_en_i(main_wr),
        .addr_i(wr_addr_i),
        .data_i(wr_data_i),
        .value_o(pin_kill_r)
    );

    // ************************************************************
    // Status pin and DAC path.
    // ************************************************************

    // Unlisted low-field codes fall back to the servo interrupt, a safe default.
    // A change of source shows on the pin one cycle after the write lands.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            status_pin_q <= 1'b0;
        end else if (dac_status_r[1:0] == dcr_pkg::DCR_STAT_DECODER) begin
            status_pin_q <= decoder_status_i;
        end else begin
            status_pin_q <= servo_irq_i;
        end
    end

    // Sample polarity and word select are registered so the DAC sees clean data.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            dac_sample_q <= 16'h0000;
            word_select_q <= 1'b0;
        end else begin
            dac_sample_q <= dac_status_r[dcr_pkg::DCR_BIT_DAC_INV] ? ~dac_sample_i : dac_sample_i;
            word_select_q <= word_select_i ^ dac_status_r[dcr_pkg::DCR_BIT_CH_SWAP];
        end
    end

    // Registered values leave the block as they are.
    assign status_pin_o = status_pin_q;
    assign dac_sample_o = dac_sample_q;
    assign word_select_o = word_select_q;
    // Plain register bits, seen by the core one cycle after the write.
    assign right_first_o = dac_status_r[dcr_pkg::DCR_BIT_CH_SWAP];
    assign pll_eq_code_o = pll_eq_r;

    // ************************************************************
    // Digital audio output.
    // ************************************************************
    // Both accuracy bits set is the off code, not a fourth accuracy level.
    assign audio_off = audio_r[dcr_pkg::DCR_BIT_ACC_HI] & audio_r[dcr_pkg::DCR_BIT_ACC_LO];

    // The output is forced low when switched off, rather than left floating.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            audio_out_q <= 1'b0;
        end else if (audio_off) begin
            audio_out_q <= 1'b0;
        end else if (audio_r[dcr_pkg::DCR_BIT_AFTER_CONCEAL]) begin
            audio_out_q <= audio_post_conceal_i;
        end else begin
            audio_out_q <= audio_pre_conceal_i;
        end
    end

    // Enable and level follow the register directly, with no extra delay.
    assign audio_out_o = audio_out_q;
    assign audio_out_enable_o = ~audio_off;
    // Level code: 0 = level II, 1 = level I, 2 = level III, 3 = off.
    assign clock_accuracy_level_o = {audio_r[dcr_pkg::DCR_BIT_ACC_HI], audio_r[dcr_pkg::DCR_BIT_ACC_LO]};
    // Flag insertion means nothing while the output is off, so it is masked there.
    assign insert_error_flags_o = audio_r[dcr_pkg::DCR_BIT_FLAGS_IN] & ~audio_off;

    // ************************************************************
    // Speed, standby and pin control.
    // ************************************************************
    // One compare serves all three decodes of the state field.
    function automatic logic state_is(input logic [3:0] reg_v, input logic [2:0] code);
        return reg_v[2:0] == code;
    endfunction

    // Unlisted state codes decode to none of the three, so the core sees no state.
    assign stop_standby_state_o = state_is(speed_r, dcr_pkg::DCR_ST_STOP);
    assign pause_standby_state_o = state_is(speed_r, dcr_pkg::DCR_ST_PAUSE);
    assign operating_state_o = state_is(speed_r, dcr_pkg::DCR_ST_OPER);
    assign double_speed_o = speed_r[3:2] == dcr_pkg::DCR_SPD_DOUBLE;

    // The pin is sampled so status reads never see it change mid-cycle.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            off_track_q <= 1'b0;
            off_track_pin_q <= 1'b0;
        end else begin
            off_track_pin_q <= off_track_input_pin_i;
            off_track_q <= pin_kill_r[dcr_pkg::DCR_BIT_EXT_OFFTRACK] ? off_track_input_pin_i
                                                                       : off_track_internal_i;
        end
    end

    // The chosen off-track source reaches the servo one cycle after it moves.
    assign off_track_o = off_track_q;
    assign off_track_pin_status_o = off_track_pin_q;
    // Kill type and pin three level are single register bits.
    assign mono_kill_o = pin_kill_r[dcr_pkg::DCR_BIT_MONO_KILL];
    assign general_output_pin_three_o = pin_kill_r[dcr_pkg::DCR_BIT_PIN_THREE];
    // Soft mute is only valid at single speed; the user must pick hard mute otherwise.
    assign hard_mute_variant_o = pin_kill_r[dcr_pkg::DCR_BIT_HARD_MUTE];
endmodule
`default_nettype wire

// file: dv/dcr_regs_props.sv
// Checker for the decoder control register bank.
// Assumes it is bound onto dcr_regs with one clock and synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module dcr_regs_props (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [3:0] wr_addr_i,
    input wire logic [3:0] wr_data_i,
    input wire logic [1:0] shadow_bank_select_i,
    input wire logic [3:0] pll_eq_code_o,
    input wire logic audio_out_o,
    input wire logic audio_out_enable_o,
    input wire logic [1:0] clock_accuracy_level_o,
    input wire logic insert_error_flags_o,
    input wire logic stop_standby_state_o,
    input wire logic pause_standby_state_o,
    input wire logic operating_state_o,
    input wire logic double_speed_o,
    input wire logic right_first_o,
    input wire logic mono_kill_o,
    input wire logic general_output_pin_three_o,
    input wire logic hard_mute_variant_o
);
    // A write only counts when the main bank is selected.
    logic wr_ok;
    assign wr_ok = wr_en_i && (shadow_bank_select_i == 2'h0);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    pll_write_a: assert property (wr_ok && wr_addr_i == 4'h9 |=> pll_eq_code_o == $past(wr_data_i))
        else $error("pll code not taken from write");
    shadow_block_a: assert property (wr_en_i && shadow_bank_select_i != 2'h0 |=> $stable(pll_eq_code_o))
        else $error("write landed while shadow bank selected");
    state_write_a: assert property (wr_ok && wr_addr_i == 4'hB |=>
        stop_standby_state_o == ($past(wr_data_i[2:0]) == 3'h0)
        && pause_standby_state_o == ($past(wr_data_i[2:0]) == 3'h2)) else $error("standby state decode wrong");
    speed_write_a: assert property (wr_ok && wr_addr_i == 4'hB |=>
        operating_state_o == ($past(wr_data_i[2:0]) == 3'h3)
        && double_speed_o == ($past(wr_data_i[3:2]) == 2'h2)) else $error("speed or state decode wrong");
    audio_enable_a: assert property (audio_out_enable_o == (clock_accuracy_level_o != 2'h3))
        else $error("audio enable disagrees with level field");
    audio_low_a: assert property (!audio_out_enable_o ##1 !audio_out_enable_o |-> !audio_out_o)
        else $error("audio output not low while off");
    reset_vals_a: assert property ($fell(rst_i) |-> pll_eq_code_o == 4'h3 && stop_standby_state_o && mono_kill_o
        && clock_accuracy_level_o == 2'h0 && !general_output_pin_three_o) else $error("reset value wrong");
    pin_write_a: assert property (wr_ok && wr_addr_i == 4'hC |=> {hard_mute_variant_o, general_output_pin_three_o,
        mono_kill_o} == $past(wr_data_i[3:1])) else $error("pin and kill field not taken");
    order_write_a: assert property (wr_ok && wr_addr_i == 4'h7 |=> right_first_o == $past(wr_data_i[3]))
        else $error("channel order not taken");
    flags_on_c: cover property (insert_error_flags_o);
    oper_c: cover property (operating_state_o && double_speed_o);
    off_c: cover property (!audio_out_enable_o);
endmodule
bind dcr_regs dcr_regs_props u_dcr_regs_props (.clock_i, .rst_i, .wr_en_i, .wr_addr_i, .wr_data_i,
    .shadow_bank_select_i, .pll_eq_code_o, .audio_out_o, .audio_out_enable_o, .clock_accuracy_level_o,
    .insert_error_flags_o, .stop_standby_state_o, .pause_standby_state_o, .operating_state_o, .double_speed_o,
    .right_first_o, .mono_kill_o, .general_output_pin_three_o, .hard_mute_variant_o);
`default_nettype wire

// file: dv/dcr_host.sv
// Host model that writes the decoder control registers.
// Assumes the bench owns the shadow bank select and calls write_reg.
`timescale 1ns/10ps
`default_nettype none
module dcr_host (
    input wire logic clock_i,
    output logic wr_en_o,
    output logic [3:0] wr_addr_o,
    output logic [3:0] wr_data_o
);
    // Idle bus at start.
    initial begin
        wr_en_o = 1'b0;
        wr_addr_o = 4'h0;
        wr_data_o = 4'h0;
    end
    // One-cycle strobe; lines are inverted afterwards so stale values are never trusted.
    task automatic write_reg(input logic [3:0] a, input logic [3:0] d);
        @(posedge clock_i);
        wr_en_o <= 1'b1;
        wr_addr_o <= a;
        wr_data_o <= d;
        @(posedge clock_i);
        wr_en_o <= 1'b0;
        wr_addr_o <= ~a;
        wr_data_o <= ~d;
    endtask
endmodule
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the decoder control register bank.
// Assumes dcr_regs and the host model; all other inputs driven here.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clock_i, rst_i, wr_en, srv, dst, oti, otp, ws_i, pre_i, post_i, st_o, ws_o, rf_o, au_o, au_en, flg;
    logic stp, pau, opr, dbl, ot_o, ot_s, mono, pin3, hmu;
    logic [3:0] wa, wd, pll;
    logic [1:0] shd, acc;
    logic [15:0] smp_i, smp_o;
    int err_total, cmp_count;
    dcr_host u_dcr_host (.clock_i(clock_i), .wr_en_o(wr_en), .wr_addr_o(wa), .wr_data_o(wd));
    dcr_regs u_dcr_regs (.clock_i(clock_i), .rst_i(rst_i), .wr_en_i(wr_en), .wr_addr_i(wa), .wr_data_i(wd),
        .shadow_bank_select_i(shd), .servo_irq_i(srv), .decoder_status_i(dst), .off_track_internal_i(oti),
        .off_track_input_pin_i(otp), .dac_sample_i(smp_i), .word_select_i(ws_i), .audio_pre_conceal_i(pre_i),
        .audio_post_conceal_i(post_i), .status_pin_o(st_o), .dac_sample_o(smp_o), .word_select_o(ws_o),
        .right_first_o(rf_o), .pll_eq_code_o(pll), .audio_out_o(au_o), .audio_out_enable_o(au_en),
        .clock_accuracy_level_o(acc), .insert_error_flags_o(flg), .stop_standby_state_o(stp),
        .pause_standby_state_o(pau), .operating_state_o(opr), .double_speed_o(dbl), .off_track_o(ot_o),
        .off_track_pin_status_o(ot_s), .mono_kill_o(mono), .general_output_pin_three_o(pin3),
        .hard_mute_variant_o(hmu));
    // Free-running 50 MHz clock.
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Write, then wait past the two-cycle data path before looking.
    task automatic w(input logic [3:0] a, input logic [3:0] d);
        u_dcr_host.write_reg(a, d);
        repeat (2) @(posedge clock_i);
        #1;
    endtask
    task automatic end_of_test;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic t_status_dac;
        w(4'h7, 4'h2);
        chk("status", 16'h1, 16'(st_o));
        w(4'h7, 4'hC);
        chk("status", 16'h0, 16'(st_o));
        chk("dac", 16'hEDCB, smp_o);
        chk("order", 16'h1, {14'h0, ws_o, rf_o});
    endtask
    task automatic t_pll;
        logic [3:0] c[5] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h3};
        foreach (c[i]) begin
            w(4'h9, c[i]);
            chk("pll", 16'(c[i]), 16'(pll));
        end
    endtask
    task automatic t_audio;
        w(4'hA, 4'h0);
        chk("aud pre", 16'h1, 16'(au_o));
        w(4'hA, 4'h1);
        chk("acc", 16'h1, 16'(acc));
        w(4'hA, 4'h4);
        chk("acc", 16'h2, 16'(acc));
        w(4'hA, 4'h2);
        chk("aud post", 16'h0, 16'(au_o));
        w(4'hA, 4'h7);
        chk("aud off", 16'h0, {14'h0, au_o, au_en});
        w(4'hA, 4'h8);
        chk("flags", 16'h3, {14'h0, flg, au_en});
    endtask
    task automatic t_speed;
        logic [3:0] c[4] = '{4'h0, 4'h2, 4'h3, 4'hB};
        logic [3:0] e[4] = '{4'h8, 4'h4, 4'h2, 4'h3};
        foreach (c[i]) begin
            w(4'hB, c[i]);
            chk("state", 16'(e[i]), {12'h0, stp, pau, opr, dbl});
        end
    endtask
    task automatic t_pins;
        w(4'hC, 4'h1);
        chk("offtrack", 16'h3, {14'h0, ot_o, ot_s});
        w(4'hC, 4'hD);
        chk("pin c", 16'hD, {12'h0, hmu, pin3, mono, ot_o});
        w(4'hC, 4'h2);
        chk("pin c", 16'h2, {12'h0, hmu, pin3, mono, ot_o});
    endtask
    task automatic t_shadow;
        @(posedge clock_i);
        shd <= 2'h1;
        w(4'h9, 4'h5);
        chk("shadow", 16'h3, 16'(pll));
        @(posedge clock_i);
        shd <= 2'h0;
        w(4'h8, 4'h5);
        chk("unmapped", 16'h3, 16'(pll));
    endtask
    // Main sequence; levels set at time zero, then reset for four cycles.
    initial begin
        // Each selectable source differs from its alternative, so every select shows at the output.
        {rst_i, srv, dst, oti, otp, ws_i, pre_i, post_i, shd, smp_i} = {8'hAE, 2'h0, 16'h1234};
        err_total = 0;
        cmp_count = 0;
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        #1;
        chk("reset", 16'h3882, {pll, stp, pau, opr, dbl, mono, pin3, hmu, rf_o, acc, au_en, flg});
        t_status_dac();
        t_pll();
        t_audio();
        t_speed();
        t_pins();
        t_shadow();
        end_of_test();
    end
    // Watchdog well beyond the 94 cycles the tests need.
    initial begin
        repeat (5000) @(posedge clock_i);
        err_total++;
        end_of_test();
    end
endmodule
`default_nettype wire
